// >>> design/ssp_pkg.sv
// package: register map, field positions and codes of the serial port block
package ssp_pkg;
  // register byte addresses
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_CTL1 = 8'h04;
  localparam logic [7:0] OFS_CTL2 = 8'h08;
  localparam logic [7:0] OFS_CTL3 = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ = 8'h14;
  localparam logic [7:0] OFS_ADDR = 8'h18;
  // control one fields
  localparam int C1_EN = 5;
  localparam int C1_CKP = 4;
  // control two fields
  localparam int C2_ACKNOWLEDGE_RECEIVED_BIT = 6;
  localparam int C2_ACKNOWLEDGE_DATA_BIT = 5;
  // control three fields
  localparam int C3_ACKNOWLEDGE_TIME_FLAG = 7;
  localparam int C3_SIE = 5;
  localparam int C3_ADDRESS_HOLD_ENABLE = 1;
  // status fields
  localparam int ST_DA = 5;
  localparam int ST_STOP = 4;
  localparam int ST_START = 3;
  localparam int ST_RW = 2;
  localparam int ST_BF = 0;
  // irq register fields
  localparam int IR_FLAG = 0;
  localparam int IR_EN = 1;
  // mode codes in control one bits 3:0
  localparam logic [3:0] MODE_SPI_MST = 4'h0;
  localparam logic [3:0] MODE_SPI_SLV = 4'h4;
  localparam logic [3:0] MODE_I2C_SLV = 4'h6;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [6:0] RST_OWN = 7'h00;
  localparam logic CKP_RST = 1'b1;
  localparam logic ACKNOWLEDGE_DATA_BIT_RST = 1'b0;
  // spi master half period in pclk cycles
  localparam logic [3:0] SPI_HALF = 4'h4;
  localparam logic [3:0] BITS_BYTE = 4'h8;
  // pin indices in the synchroniser vector
  localparam int P_SDA = 0;
  localparam int P_SCL = 1;
  localparam int P_SCK = 2;
  localparam int P_SDI = 3;
  localparam int P_SSN = 4;
  localparam int NPIN = 5;

  typedef enum logic [6:0] {
    S_IDLE = 7'b0000001,
    S_ADDR = 7'b0000010,
    S_AACK = 7'b0000100,
    S_TXW = 7'b0001000,
    S_TX = 7'b0010000,
    S_TACK = 7'b0100000,
    S_SPI = 7'b1000000
  } ssp_state_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } ssp_apb_s;
endpackage

// >>> design/ssp_top.sv
// serial port block: spi master/slave with sleep, i2c 7-bit slave transmit
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module ssp_top
  import ssp_pkg::*;
(
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped
  input wire logic sleep, // device is asleep
  output logic port_interrupt_flag, // sticky event flag
  output logic wake_req, // flag gated by enable
  input wire logic sck_in, // spi clock in
  output logic sck_out, // spi clock out
  output logic sck_oe, // spi clock drive in master mode
  input wire logic sdi, // spi data in
  output logic sdo, // spi data out
  input wire logic ss_n, // spi slave select
  input wire logic scl_in, // i2c clock level
  output logic scl_out, // i2c clock drive value
  output logic scl_oe, // i2c clock driven low
  input wire logic sda_in, // i2c data level
  output logic sda_out, // i2c data drive value
  output logic sda_oe // i2c data driven low
);
  typedef struct packed {
    logic [7:0] dbuf;
    logic bf;
    logic en;
    logic clock_release_bit;
    logic [3:0] mode;
    logic acknowledge_data_bit;
    logic acknowledge_received_bit;
    logic acknowledge_time_flag;
    logic sie;
    logic address_hold_enable;
    logic da;
    logic st;
    logic sp;
    logic rw;
    logic pif;
    logic pie;
    logic [6:0] own;
    logic [7:0] sh;
    logic [3:0] cnt;
    ssp_state_e fsm;
    logic [3:0] div;
    logic busy;
    logic sck;
    logic sdo;
    logic scl_oe;
    logic sda_oe;
    logic [NPIN-1:0] s1;
    logic [NPIN-1:0] s2;
    logic [NPIN-1:0] s3;
    logic [31:0] rd;
  } ssp_reg_s;

  ssp_reg_s r;
  ssp_reg_s next_r;
  ssp_apb_s bus;

  // true when the address hits one of the mapped registers
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFS_DATA) || (a == OFS_CTL1) || (a == OFS_CTL2) ||
             (a == OFS_CTL3) || (a == OFS_STAT) || (a == OFS_IRQ) ||
             (a == OFS_ADDR);
  endfunction

  // read mux of all registers
  function automatic logic [31:0] rdmux(input ssp_reg_s q, input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      OFS_DATA: v = q.dbuf;
      OFS_CTL1: v = {2'b00, q.en, q.clock_release_bit, q.mode};
      OFS_CTL2: v = {1'b0, q.acknowledge_received_bit, q.acknowledge_data_bit, 5'h00};
      OFS_CTL3: v = {q.acknowledge_time_flag, 1'b0, q.sie, 3'b000, q.address_hold_enable, 1'b0};
      OFS_STAT: v = {2'b00, q.da, q.sp, q.st, q.rw, 1'b0, q.bf};
      OFS_IRQ: v = {6'h00, q.pie, q.pif};
      OFS_ADDR: v = {1'b0, q.own};
      default: v = 8'h00;
    endcase
    rdmux = {24'h000000, v};
  endfunction

  assign bus = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

  // next state of the whole block
  always_comb begin
    logic acc;
    logic wr;
    logic rdbuf;
    logic sck_r;
    logic sck_f;
    logic scl_r;
    logic scl_f;
    logic start;
    logic stop;
    logic pulse;
    logic spi_slv;
    logic i2c;
    logic set_flag;
    acc = bus.psel && bus.penable;
    wr = acc && bus.pwrite && mapped(bus.paddr);
    rdbuf = acc && !bus.pwrite && (bus.paddr == OFS_DATA);
    next_r = r;
    set_flag = 1'b0;
    // pin synchronisers; edges are judged on stages two and three only
    next_r.s1 = {ss_n, sdi, sck_in, scl_in, sda_in};
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    sck_r = r.s2[P_SCK] && !r.s3[P_SCK];
    sck_f = !r.s2[P_SCK] && r.s3[P_SCK];
    scl_r = r.s2[P_SCL] && !r.s3[P_SCL];
    scl_f = !r.s2[P_SCL] && r.s3[P_SCL];
    start = r.s2[P_SCL] && r.s3[P_SCL] && !r.s2[P_SDA] && r.s3[P_SDA];
    stop = r.s2[P_SCL] && r.s3[P_SCL] && r.s2[P_SDA] && !r.s3[P_SDA];
    spi_slv = r.en && (r.mode == MODE_SPI_SLV);
    i2c = r.en && (r.mode == MODE_I2C_SLV);
    // read data is prepared in the setup cycle so pready can stay high
    if (bus.psel && !bus.penable) begin
      next_r.rd = rdmux(r, bus.paddr);
    end
    // register writes
    if (wr) begin
      unique case (bus.paddr)
        OFS_DATA: begin
          next_r.dbuf = bus.pwdata[7:0];
          next_r.bf = 1'b1;
          if (r.en && (r.mode == MODE_SPI_MST) && !r.busy) begin
            next_r.sh = bus.pwdata[7:0];
            next_r.sdo = bus.pwdata[7];
            next_r.busy = 1'b1;
            next_r.cnt = 4'h0;
            next_r.div = 4'h0;
          end else if (spi_slv) begin
            next_r.sh = bus.pwdata[7:0];
            next_r.sdo = bus.pwdata[7];
          end
        end
        OFS_CTL1: begin
          next_r.en = bus.pwdata[C1_EN];
          next_r.clock_release_bit = bus.pwdata[C1_CKP];
          next_r.mode = bus.pwdata[3:0];
        end
        OFS_CTL2: next_r.acknowledge_data_bit = bus.pwdata[C2_ACKNOWLEDGE_DATA_BIT];
        OFS_CTL3: begin
          next_r.sie = bus.pwdata[C3_SIE];
          next_r.address_hold_enable = bus.pwdata[C3_ADDRESS_HOLD_ENABLE];
        end
        OFS_IRQ: begin
          // write one clears the flag; a new event this cycle still sets it
          if (bus.pwdata[IR_FLAG]) begin
            next_r.pif = 1'b0;
          end
          next_r.pie = bus.pwdata[IR_EN];
        end
        OFS_ADDR: next_r.own = bus.pwdata[6:0];
        default: next_r.own = r.own;
      endcase
    end
    if (rdbuf) begin
      next_r.bf = 1'b0;
    end
    // spi master: divider simply stops counting while asleep
    if (r.en && (r.mode == MODE_SPI_MST) && r.busy && !sleep) begin
      next_r.div = r.div + 4'h1;
      if (r.div == SPI_HALF - 4'h1) begin
        next_r.div = 4'h0;
        next_r.sck = !r.sck;
        if (!r.sck) begin
          next_r.sh = {r.sh[6:0], r.s2[P_SDI]};
          next_r.cnt = r.cnt + 4'h1;
        end else if (r.cnt == BITS_BYTE) begin
          next_r.busy = 1'b0;
          next_r.dbuf = r.sh;
          next_r.bf = 1'b1;
          set_flag = 1'b1;
        end else begin
          next_r.sdo = r.sh[7];
        end
      end
    end
    // spi slave: follows the bus clock, which keeps running in sleep
    if (spi_slv) begin
      if (r.s2[P_SSN]) begin
        next_r.cnt = 4'h0;
      end else if (sck_r) begin
        next_r.sh = {r.sh[6:0], r.s2[P_SDI]};
        next_r.cnt = r.cnt + 4'h1;
        if (r.cnt == BITS_BYTE - 4'h1) begin
          next_r.cnt = 4'h0;
          next_r.dbuf = {r.sh[6:0], r.s2[P_SDI]};
          next_r.bf = 1'b1;
          set_flag = 1'b1;
        end
      end else if (sck_f) begin
        next_r.sdo = r.sh[7];
      end
    end
    // i2c slave transmit sequence
    if (i2c) begin
      unique case (r.fsm)
        S_ADDR: begin
          // bits are counted on rises, so the fall that closes the start is not taken as a bit
          if (scl_r) begin
            next_r.sh = {r.sh[6:0], r.s2[P_SDA]};
            next_r.cnt = r.cnt + 4'h1;
          end
          if (scl_f) begin
            if (r.cnt == BITS_BYTE) begin
              if (r.sh[7:1] == r.own) begin
                next_r.dbuf = r.sh;
                next_r.bf = 1'b1;
                next_r.rw = r.sh[0];
                next_r.da = 1'b0;
                next_r.acknowledge_time_flag = 1'b1;
                next_r.fsm = S_AACK;
                next_r.sda_oe = !r.acknowledge_data_bit;
                if (r.address_hold_enable) begin
                  next_r.clock_release_bit = 1'b0;
                  set_flag = 1'b1;
                end
              end else begin
                next_r.fsm = S_IDLE;
              end
            end
          end
        end
        S_AACK: begin
          next_r.sda_oe = !r.acknowledge_data_bit;
          if (scl_f) begin
            next_r.acknowledge_time_flag = 1'b0;
            next_r.sda_oe = 1'b0;
            if (r.acknowledge_data_bit || !r.rw) begin
              next_r.fsm = S_IDLE;
            end else begin
              next_r.clock_release_bit = 1'b0;
              set_flag = 1'b1;
              next_r.fsm = S_TXW;
            end
          end
        end
        S_TXW: begin
          // byte is taken from the buffer only when software releases scl
          // bit 7 is put out while scl is still held, so sda never moves with scl high
          next_r.sda_oe = !r.dbuf[7];
          if (r.clock_release_bit) begin
            next_r.sh = r.dbuf;
            next_r.bf = 1'b0;
            next_r.da = 1'b1;
            next_r.cnt = 4'h0;
            next_r.sda_oe = !r.dbuf[7];
            next_r.fsm = S_TX;
          end
        end
        S_TX: begin
          if (scl_f) begin
            next_r.cnt = r.cnt + 4'h1;
            next_r.sh = {r.sh[6:0], 1'b0};
            next_r.sda_oe = !r.sh[6];
            if (r.cnt == BITS_BYTE - 4'h1) begin
              next_r.sda_oe = 1'b0;
              next_r.fsm = S_TACK;
            end
          end
        end
        S_TACK: begin
          if (scl_r) begin
            next_r.acknowledge_received_bit = r.s2[P_SDA];
          end
          if (scl_f) begin
            if (r.acknowledge_received_bit) begin
              next_r.fsm = S_IDLE;
            end else begin
              next_r.clock_release_bit = 1'b0;
              set_flag = 1'b1;
              next_r.fsm = S_TXW;
            end
          end
        end
        default: next_r.sda_oe = 1'b0;
      endcase
      if (start) begin
        next_r.st = 1'b1;
        next_r.sp = 1'b0;
        next_r.cnt = 4'h0;
        next_r.sda_oe = 1'b0;
        next_r.fsm = S_ADDR;
        if (r.sie) begin
          set_flag = 1'b1;
        end
      end else if (stop) begin
        next_r.sp = 1'b1;
        next_r.st = 1'b0;
        next_r.sda_oe = 1'b0;
        next_r.fsm = S_IDLE;
      end
    end else begin
      next_r.fsm = spi_slv ? S_SPI : S_IDLE;
      next_r.sda_oe = 1'b0;
    end
    // scl is stretched only while the release bit is clear mid-transfer
    next_r.scl_oe = i2c && !next_r.clock_release_bit &&
                    ((next_r.fsm == S_AACK) || (next_r.fsm == S_TXW));
    if (set_flag) begin
      next_r.pif = 1'b1;
    end
  end

  // single state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{dbuf: RST_BYTE, bf: 1'b0, en: 1'b0, clock_release_bit: CKP_RST, mode: MODE_SPI_MST,
             acknowledge_data_bit: ACKNOWLEDGE_DATA_BIT_RST, acknowledge_received_bit: 1'b0, acknowledge_time_flag: 1'b0, sie: 1'b0, address_hold_enable: 1'b0,
             da: 1'b0, st: 1'b0, sp: 1'b0, rw: 1'b0, pif: 1'b0, pie: 1'b0,
             own: RST_OWN, sh: RST_BYTE, cnt: 4'h0, fsm: S_IDLE, div: 4'h0,
             busy: 1'b0, sck: 1'b0, sdo: 1'b0, scl_oe: 1'b0, sda_oe: 1'b0,
             s1: '1, s2: '1, s3: '1, rd: 32'h00000000};
    end else begin
      r <= next_r;
    end
  end

  // outputs
  assign prdata = r.rd;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);
  assign port_interrupt_flag = r.pif;
  assign wake_req = r.pif && r.pie;
  assign sck_out = r.sck;
  assign sck_oe = r.en && (r.mode == MODE_SPI_MST);
  assign sdo = r.sdo;
  assign scl_out = 1'b0;
  assign scl_oe = r.scl_oe;
  assign sda_out = 1'b0;
  assign sda_oe = r.sda_oe;
endmodule
`default_nettype wire

// >>> test/ssp_chk.sv
// checker: port-level properties of the serial port block
`timescale 1ns/100ps
`default_nettype none
module ssp_chk
  import ssp_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic sleep, // device asleep
  input wire logic port_interrupt_flag, // event flag
  input wire logic wake_req, // gated flag
  input wire logic sck_out, // spi master clock
  input wire logic scl_oe, // clock pulled low
  input wire logic scl_out, // clock drive value
  input wire logic sda_out // data drive value
);
  logic wr_ckp;
  // software write that sets the release bit
  assign wr_ckp = psel && penable && pwrite && paddr == OFS_CTL1 && pwdata[C1_CKP];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence sleep_two;
    sleep ##1 sleep;
  endsequence
  sequence stretch_start;
    $rose(scl_oe);
  endsequence
  ckp_release_a: assert property (wr_ckp |-> ##[1:2] !scl_oe)
    else $error("clock still held after release write");
  hold_low_a: assert property (scl_oe && !wr_ckp && !$past(wr_ckp) |=> scl_oe)
    else $error("clock let go without release write");
  stretch_flag_a: assert property (stretch_start |-> ##[0:2] port_interrupt_flag)
    else $error("stretch without event flag");
  wake_gate_a: assert property (wake_req |-> port_interrupt_flag)
    else $error("wake without flag");
  sleep_freeze_a: assert property (sleep_two |-> $stable(sck_out))
    else $error("spi clock moved during sleep");
  unmapped_err_a: assert property (psel && penable && paddr > OFS_ADDR |-> pslverr)
    else $error("no error on unmapped access");
  zero_wait_a: assert property (psel && penable |-> pready)
    else $error("access not answered");
  open_drain_a: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("open drain pin driven high");
endmodule
bind ssp_top ssp_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .sleep(sleep),
  .port_interrupt_flag(port_interrupt_flag), .wake_req(wake_req), .sck_out(sck_out), .scl_oe(scl_oe),
  .scl_out(scl_out), .sda_out(sda_out));
`default_nettype wire

// >>> test/ssp_i2c_mst.sv
// partner: behavioural i2c bus master for slave transmit
`timescale 1ns/100ps
`default_nettype none
module ssp_i2c_mst (
  input wire logic clk, // bench clock; pins move on its falling edge
  input wire logic scl, // clock line level
  input wire logic sda, // data line level
  output logic scl_low, // pull clock low
  output logic sda_low // pull data low
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // falling edges only, so no pin change meets the slave's sampling edge
  task automatic gap(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one pulse; waiting on the line honours slave clock stretching
  task automatic bit_x(input logic v, output logic r);
    scl_low = 1'b1;
    gap(3);
    sda_low = !v;
    gap(2);
    scl_low = 1'b0;
    wait (scl === 1'b1);
    gap(5);
    r = sda;
  endtask
  // data falls while clock high
  task automatic start();
    gap(5);
    sda_low = 1'b1;
    gap(5);
  endtask
  task automatic wbyte(input logic [7:0] v, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(v[i], r);
    bit_x(1'b1, a);
  endtask
  // data line released so the slave alone drives it
  task automatic rbyte(input logic a, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, v[i]);
    bit_x(a, r);
  endtask
  // data rises while clock high
  task automatic stop();
    scl_low = 1'b1;
    gap(3);
    sda_low = 1'b1;
    gap(2);
    scl_low = 1'b0;
    wait (scl === 1'b1);
    gap(5);
    sda_low = 1'b0;
    gap(5);
  endtask
endmodule
`default_nettype wire

// >>> test/tb_sync_serial_sleep_and_i2c_slave_tx.sv
// testbench: apb driven tests of the serial port block
`timescale 1ns/100ps
`default_nettype none
module tb_sync_serial_sleep_and_i2c_slave_tx import ssp_pkg::*;;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sleep = 1'b0;
  logic sck_in = 1'b0, sdi = 1'b0, ss_n = 1'b1, ack;
  logic [7:0] paddr = 8'h00, b;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, flag, wake, sdo, sck_oe, scl_oe, sda_oe, m_scl, m_sda, scl, sda;
  logic [31:0] tx [2] = '{32'hC3, 32'h5A};
  int failures = 0, checks_done = 0;
  // pull-up lines: low while any party pulls
  assign scl = !(scl_oe || m_scl);
  assign sda = !(sda_oe || m_sda);
  always #4 pclk = !pclk;
  ssp_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep(sleep),
    .port_interrupt_flag(flag), .wake_req(wake), .sck_in(sck_in), .sck_out(), .sck_oe(sck_oe), .sdi(sdi),
    .sdo(sdo), .ss_n(ss_n), .scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda), .sda_out(),
    .sda_oe(sda_oe));
  ssp_i2c_mst mst_u (.clk(pclk), .scl(scl), .sda(sda), .scl_low(m_scl), .sda_low(m_sda));
  task automatic finish_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer, entered just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  // bounded wait for the event flag, then clear it
  task automatic wflag(input logic [31:0] irq);
    int n;
    n = 0;
    while (flag !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    chk(flag, 1'b1);
    xfer(1'b1, OFS_IRQ, irq);
  endtask
  // link clock runs only inside the byte; 80 ns period, driven on pclk edges
  task automatic spi_byte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      sdi <= v[i];
      repeat (5) @(posedge pclk);
      sck_in <= 1'b1;
      repeat (5) @(posedge pclk);
      sck_in <= 1'b0;
    end
    repeat (8) @(posedge pclk);
  endtask
  initial begin
    #200000;
    failures++;
    finish_test();
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    sdi <= 1'b1;
    @(posedge pclk);
    rc(OFS_CTL1, 32'h10);
    rc(OFS_STAT, 32'h0);
    rc(OFS_IRQ, 32'h0);
    rc(8'h1C, 32'h0);
    $display("test reset done");
    // master byte frozen in its third bit by sleep
    xfer(1'b1, OFS_CTL1, 32'h30);
    xfer(1'b1, OFS_DATA, 32'hA5);
    chk(sck_oe, 1'b1);
    chk(sdo, 1'b1);
    repeat (20) @(posedge pclk);
    sleep <= 1'b1;
    repeat (100) @(posedge pclk);
    chk(flag, 1'b0);
    sleep <= 1'b0;
    wflag(32'h1);
    rc(OFS_DATA, 32'hFF);
    $display("test spi master sleep done");
    // slave bytes shifted in while asleep
    xfer(1'b1, OFS_CTL1, 32'h34);
    xfer(1'b1, OFS_IRQ, 32'h2);
    sleep <= 1'b1;
    ss_n <= 1'b0;
    spi_byte(8'h3C);
    chk(sdo, 1'b0);
    chk(sck_oe, 1'b0);
    chk(wake, 1'b1);
    wflag(32'h1);
    spi_byte(8'hC6);
    chk(sdo, 1'b1);
    chk(flag, 1'b1);
    chk(wake, 1'b0);
    sleep <= 1'b0;
    ss_n <= 1'b1;
    rc(OFS_DATA, 32'hC6);
    // stale flag from the last slave byte would be taken for the start event
    xfer(1'b1, OFS_IRQ, 32'h1);
    $display("test spi slave sleep done");
    // slave transmit, two bytes, last one refused by the master
    xfer(1'b1, OFS_ADDR, 32'h2A);
    xfer(1'b1, OFS_CTL3, 32'h22);
    xfer(1'b1, OFS_CTL1, 32'h36);
    fork
      begin
        mst_u.start();
        mst_u.wbyte(8'h55, ack);
        chk(ack, 1'b0);
        mst_u.rbyte(1'b0, b);
        chk(b, 8'hC3);
        mst_u.rbyte(1'b1, b);
        chk(b, 8'h5A);
        mst_u.stop();
      end
      begin
        wflag(32'h1);
        rc(OFS_STAT, 32'h08);
        wflag(32'h1);
        rc(OFS_CTL3, 32'hA2);
        rc(OFS_STAT, 32'h0D);
        rc(OFS_DATA, 32'h55);
        rc(OFS_STAT, 32'h0C);
        xfer(1'b1, OFS_CTL2, 32'h0);
        xfer(1'b1, OFS_CTL1, 32'h36);
        foreach (tx[i]) begin
          wflag(32'h1);
          rc(OFS_CTL2, 32'h0);
          xfer(1'b1, OFS_DATA, tx[i]);
          xfer(1'b0, OFS_STAT, 32'h0);
          chk(q[ST_BF], 1'b1);
          xfer(1'b1, OFS_CTL1, 32'h36);
        end
      end
    join
    rc(OFS_CTL2, 32'h40);
    xfer(1'b0, OFS_STAT, 32'h0);
    chk(q[ST_STOP:ST_START], 2'b10);
    chk(scl, 1'b1);
    $display("test i2c slave transmit done");
    finish_test();
  end
endmodule
`default_nettype wire
